// ---- verilog/adcc_consts.svh ----
// constants for the converter control block
`ifndef ADCC_CONSTS_SVH
`define ADCC_CONSTS_SVH

// clock and timing figures
`define ADCC_CLK_MHZ       125
`define ADCC_T_PU_MS       5
`define ADCC_T_RST_MS      5
`define ADCC_T_CAL_NS      2000
`define ADCC_T_CYCLE_NS    1000
`define ADCC_PU_CYC        (`ADCC_T_PU_MS * 1000 * `ADCC_CLK_MHZ)
`define ADCC_RST_CYC       (`ADCC_T_RST_MS * 1000 * `ADCC_CLK_MHZ)
`define ADCC_CAL_CYC       ((`ADCC_T_CAL_NS * `ADCC_CLK_MHZ + 999) / 1000)
`define ADCC_GAP_CYC       ((`ADCC_T_CYCLE_NS * `ADCC_CLK_MHZ) / 1000)

// register offsets
`define ADCC_OFS_GENERAL   8'h00
`define ADCC_OFS_STATUS    8'h01
`define ADCC_OFS_AVG_SETUP 8'h02
`define ADCC_OFS_CHAN_SEL  8'h03
`define ADCC_OFS_PIN_SEL   8'h04
`define ADCC_OFS_DIR       8'h05
`define ADCC_OFS_DRIVE     8'h06
`define ADCC_OFS_OUT_LVL   8'h07
`define ADCC_OFS_IN_LVL    8'h08
`define ADCC_OFS_AUTO_MASK 8'h09
`define ADCC_OFS_THR_HI_H  8'h0a
`define ADCC_OFS_THR_HI_L  8'h0b
`define ADCC_OFS_THR_LO_H  8'h0c
`define ADCC_OFS_THR_LO_L  8'h0d
`define ADCC_OFS_WIN_FLAG  8'h0e
`define ADCC_OFS_BUS_ADDR  8'h0f
`define ADCC_OFS_RES_BASE  8'h10

// general register bits
`define ADCC_GEN_RST       0
`define ADCC_GEN_CAL       1
`define ADCC_GEN_STATS     2
`define ADCC_GEN_START     3
`define ADCC_GEN_AUTO      4

// status register bits
`define ADCC_ST_AVG_DONE   0
`define ADCC_ST_BUSY       1
`define ADCC_ST_READY      2

// reset values
`define ADCC_ADDR_BASE     7'h10
`define ADCC_RST_MASK      8'h00
`define ADCC_RST_THR_HI    12'hfff
`define ADCC_RST_THR_LO    12'h000

`endif

// ---- verilog/adcc_pkg.sv ----
// types of the converter control block
package adcc_pkg;
  typedef enum logic [1:0] {
    CV_IDLE,
    CV_CONV,
    CV_GAP,
    CV_FIN
  } adcc_conv_state_t;

  typedef enum logic [1:0] {
    SRC_MAN,
    SRC_READ,
    SRC_AUTO
  } adcc_src_t;
endpackage : adcc_pkg

// ---- verilog/adcc_avg.sv ----
// averaging accumulator with 16-bit scaled result
`timescale 1ns/1ps
module adcc_avg (
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  input  wire logic        clear_i,
  input  wire logic        add_i,
  input  wire logic [11:0] sample_i,
  input  wire logic [2:0]  osr_i,
  output logic             last_o,
  output logic             done_o,
  output logic [15:0]      result_o
);
  logic [18:0] sum_q;
  logic [7:0]  cnt_q;
  logic [18:0] total;
  logic [22:0] scaled;
  logic [15:0] mean16;
  logic [7:0]  target;

  assign total  = sum_q + {7'h00, sample_i};
  assign target = 8'h01 << osr_i;
  assign last_o = (cnt_q + 8'h01) == target;
  assign scaled = {total, 4'h0} >> osr_i;
  assign mean16 = scaled[15:0];

  always_ff @(posedge mclk_i) begin
    if (!resetn_i || clear_i) begin
      sum_q <= 19'h00000;
      cnt_q <= 8'h00;
    end else if (add_i) begin
      sum_q <= total;
      cnt_q <= cnt_q + 8'h01;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      done_o   <= 1'b0;
      result_o <= 16'h0000;
    end else begin
      done_o <= add_i && last_o && !clear_i;
      // [RQ24] mean scaled to full
      if (add_i && last_o && !clear_i) begin
        result_o <= mean16 + {12'h000, mean16[15:12]};
      end
    end
  end
endmodule : adcc_avg

// ---- verilog/adcc_top.sv ----
// converter digital control: reset, address, averaging, gpio
//
// Contract
// [RQ1] after any reset all eight channels are analog inputs
// [RQ2] soft reset completes within 5 ms, then its bit self-clears
// [RQ3] device needs up to 5 ms after power-up before it is ready
// [RQ4] calibration bit starts offset calibration and self-clears when done
// [RQ5] host polls the calibration bit until it reads zero
// [RQ6] bus address taken once at power-up from the strap level
// [RQ7] address held until power-up, device reset or a new programmed one
// [RQ8] strap level picks one of eight addresses 10h to 17h
// [RQ9] results are 12-bit straight binary, 000 to fff
// [RQ10] three-bit field enables averaging, one setting for all channels
// [RQ11] averaging gives a 16-bit result, lsb is reference over 2^16
// [RQ12] host starts only the first conversion of an averaging run
// [RQ13] device triggers remaining conversions from its own timing
// [RQ14] bus-read averaging holds the bus clock low until complete
// [RQ15] host avoids stretching via statistics enable and start bit
// [RQ16] non-stretching run reports completion in a pollable done flag
// [RQ17] start-bit results go to per-channel low and high byte registers
// [RQ18] autonomous mode averages enabled analog channels in turn
// [RQ19] window compare uses top 12 bits of the 16-bit average
// [RQ20] per-channel select makes gpio, direction mask picks in or out
// [RQ21] input register reads digital inputs, output register sets levels
// [RQ22] per-channel drive mask picks open-drain or push-pull
// [RQ23] decode: sel 0 analog, dir 0 input, drive 0 open-drain, 1 push-pull
// [RQ24] averaged result is the sample mean scaled to 16-bit full scale
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "adcc_consts.svh"
module adcc_top #(
  parameter int unsigned PU_CYCLES  = `ADCC_PU_CYC,
  parameter int unsigned RST_CYCLES = `ADCC_RST_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [7:0]       reg_rdata_o,
  input  wire logic [2:0]  addr_strap_i,
  output logic [6:0]       bus_addr_o,
  output logic             ready_o,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n_o,
  output logic             conv_start_o,
  output logic [2:0]       conv_chan_o,
  input  wire logic        conv_done_i,
  input  wire logic [11:0] conv_data_i,
  output logic             cal_run_o,
  output logic [7:0]       analog_en_o,
  input  wire logic [7:0]  gpio_i,
  output logic [7:0]       gpio_o,
  output logic [7:0]       gpio_oe_n_o
);
  localparam logic [19:0] PU_LAST  = 20'(PU_CYCLES - 1);
  localparam logic [19:0] RST_LAST = 20'(RST_CYCLES - 1);
  localparam logic [7:0]  CAL_LAST = 8'(`ADCC_CAL_CYC - 1);
  localparam logic [7:0]  GAP_LAST = 8'(`ADCC_GAP_CYC - 1);

  adcc_pkg::adcc_conv_state_t state_q;
  adcc_pkg::adcc_src_t        src_q;

  logic        init;
  logic        rst_fire;
  logic        rst_bit_q;
  logic [19:0] rst_cnt_q;
  logic        pu_busy_q;
  logic [19:0] pu_cnt_q;
  logic        cal_bit_q;
  logic [7:0]  cal_cnt_q;
  logic        statistics_enable_bit_q;
  logic        auto_en_q;
  logic [2:0]  osr_q;
  logic [2:0]  chan_sel_q;
  logic [7:0]  pin_sel_q;
  logic [7:0]  dir_q;
  logic [7:0]  drive_q;
  logic [7:0]  out_lvl_q;
  logic [7:0]  auto_mask_q;
  logic [11:0] thr_hi_q;
  logic [11:0] thr_lo_q;
  logic [7:0]  win_flag_q;
  logic        avg_done_q;
  logic [6:0]  bus_addr_q;
  logic [15:0] latest_q [8];
  logic [2:0]  strap_s1_q;
  logic [2:0]  strap_s2_q;
  logic [7:0]  gpio_s1_q;
  logic [7:0]  gpio_s2_q;
  logic        scl_s1_q;
  logic        scl_s2_q;
  logic        stretch_q;
  logic        hold_q;
  logic [2:0]  cur_ch_q;
  logic [2:0]  auto_ch_q;
  logic [7:0]  gap_cnt_q;
  logic [7:0]  in_lvl;
  logic [7:0]  auto_eff;
  logic        wr_gen;
  logic        man_start;
  logic        read_start;
  logic        auto_start;
  logic        avg_last;
  logic        avg_done;
  logic [15:0] avg_res;
  logic        avg_clear;
  logic        avg_add;
  logic [7:0]  rd_mux;
  logic [11:0] top12;

  assign wr_gen = reg_wr_i && (reg_addr_i == `ADCC_OFS_GENERAL);
  assign init   = !resetn_i || rst_fire;

  // [RQ2] soft reset timer
  assign rst_fire = rst_bit_q && (rst_cnt_q == RST_LAST);
  always_ff @(posedge mclk_i) begin
    if (init) begin
      rst_bit_q <= 1'b0;
      rst_cnt_q <= 20'h00000;
    end else if (rst_bit_q) begin
      rst_cnt_q <= rst_cnt_q + 20'h00001;
    end else if (wr_gen && reg_wdata_i[`ADCC_GEN_RST]) begin
      rst_bit_q <= 1'b1;
    end
  end

  // [RQ3] power-up wait
  always_ff @(posedge mclk_i) begin
    if (init) begin
      pu_busy_q <= 1'b1;
      pu_cnt_q  <= 20'h00000;
    end else if (pu_busy_q) begin
      pu_cnt_q <= pu_cnt_q + 20'h00001;
      if (pu_cnt_q == PU_LAST) begin
        pu_busy_q <= 1'b0;
      end
    end
  end
  assign ready_o = !pu_busy_q;

  // pin synchronisers
  always_ff @(posedge mclk_i) begin
    strap_s1_q <= addr_strap_i;
    strap_s2_q <= strap_s1_q;
    gpio_s1_q  <= gpio_i;
    gpio_s2_q  <= gpio_s1_q;
    scl_s1_q   <= scl_i;
    scl_s2_q   <= scl_s1_q;
  end

  // [RQ6] [RQ7] [RQ8] strap capture
  always_ff @(posedge mclk_i) begin
    if (init) begin
      bus_addr_q <= `ADCC_ADDR_BASE;
    end else if (pu_busy_q && pu_cnt_q == PU_LAST) begin
      bus_addr_q <= `ADCC_ADDR_BASE | {4'h0, strap_s2_q};
    end else if (reg_wr_i && reg_addr_i == `ADCC_OFS_BUS_ADDR) begin
      bus_addr_q <= reg_wdata_i[6:0];
    end
  end
  assign bus_addr_o = bus_addr_q;

  // [RQ4] calibration run
  always_ff @(posedge mclk_i) begin
    if (init) begin
      cal_bit_q <= 1'b0;
      cal_cnt_q <= 8'h00;
    end else if (cal_bit_q) begin
      cal_cnt_q <= cal_cnt_q + 8'h01;
      if (cal_cnt_q == CAL_LAST) begin
        cal_bit_q <= 1'b0;
      end
    end else if (wr_gen && reg_wdata_i[`ADCC_GEN_CAL]) begin
      cal_bit_q <= 1'b1;
      cal_cnt_q <= 8'h00;
    end
  end
  assign cal_run_o = cal_bit_q;

  // [RQ1] configuration registers
  always_ff @(posedge mclk_i) begin
    if (init) begin
      statistics_enable_bit_q  <= 1'b0;
      auto_en_q   <= 1'b0;
      osr_q       <= 3'h0;
      chan_sel_q  <= 3'h0;
      pin_sel_q   <= `ADCC_RST_MASK;
      dir_q       <= `ADCC_RST_MASK;
      drive_q     <= `ADCC_RST_MASK;
      out_lvl_q   <= `ADCC_RST_MASK;
      auto_mask_q <= `ADCC_RST_MASK;
      thr_hi_q    <= `ADCC_RST_THR_HI;
      thr_lo_q    <= `ADCC_RST_THR_LO;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        `ADCC_OFS_GENERAL: begin
          statistics_enable_bit_q <= reg_wdata_i[`ADCC_GEN_STATS];
          auto_en_q  <= reg_wdata_i[`ADCC_GEN_AUTO];
        end
        // [RQ10] common averaging field
        `ADCC_OFS_AVG_SETUP: osr_q       <= reg_wdata_i[2:0];
        `ADCC_OFS_CHAN_SEL:  chan_sel_q  <= reg_wdata_i[2:0];
        `ADCC_OFS_PIN_SEL:   pin_sel_q   <= reg_wdata_i;
        `ADCC_OFS_DIR:       dir_q       <= reg_wdata_i;
        `ADCC_OFS_DRIVE:     drive_q     <= reg_wdata_i;
        `ADCC_OFS_OUT_LVL:   out_lvl_q   <= reg_wdata_i;
        `ADCC_OFS_AUTO_MASK: auto_mask_q <= reg_wdata_i;
        `ADCC_OFS_THR_HI_H:  thr_hi_q    <= {reg_wdata_i, thr_hi_q[3:0]};
        `ADCC_OFS_THR_HI_L:  thr_hi_q    <= {thr_hi_q[11:4], reg_wdata_i[3:0]};
        `ADCC_OFS_THR_LO_H:  thr_lo_q    <= {reg_wdata_i, thr_lo_q[3:0]};
        `ADCC_OFS_THR_LO_L:  thr_lo_q    <= {thr_lo_q[11:4], reg_wdata_i[3:0]};
        default: begin
        end
      endcase
    end
  end

  // per-channel pin decode
  generate
    for (genvar ch = 0; ch < 8; ch++) begin : g_pin
      // [RQ20] [RQ23] select and direction
      assign analog_en_o[ch] = !pin_sel_q[ch];
      assign in_lvl[ch]      = pin_sel_q[ch] && !dir_q[ch] && gpio_s2_q[ch];
      assign auto_eff[ch]    = auto_mask_q[ch] && !pin_sel_q[ch];
      // [RQ22] [RQ23] drive type
      assign gpio_oe_n_o[ch] = !(pin_sel_q[ch] && dir_q[ch] &&
                                 (drive_q[ch] || !out_lvl_q[ch]));
      // [RQ21] output levels
      assign gpio_o[ch]      = out_lvl_q[ch];
    end
  endgenerate

  // [RQ12] [RQ15] run starts
  assign man_start  = wr_gen && reg_wdata_i[`ADCC_GEN_START] &&
                      !pin_sel_q[chan_sel_q];
  assign read_start = reg_rd_i && (osr_q != 3'h0) && !statistics_enable_bit_q &&
                      (reg_addr_i == (`ADCC_OFS_RES_BASE |
                                      {4'h0, chan_sel_q, 1'b1})) &&
                      !pin_sel_q[chan_sel_q];
  assign auto_start = auto_en_q && auto_eff[auto_ch_q];

  assign avg_clear = (state_q == adcc_pkg::CV_IDLE);
  assign avg_add   = (state_q == adcc_pkg::CV_CONV) && conv_done_i;

  adcc_avg u_avg (
    .mclk_i   (mclk_i),
    .resetn_i (!init),
    .clear_i  (avg_clear),
    .add_i    (avg_add),
    .sample_i (conv_data_i),
    .osr_i    (osr_q),
    .last_o   (avg_last),
    .done_o   (avg_done),
    .result_o (avg_res)
  );

  // [RQ13] conversion sequencer
  always_ff @(posedge mclk_i) begin
    if (init) begin
      state_q      <= adcc_pkg::CV_IDLE;
      src_q        <= adcc_pkg::SRC_MAN;
      cur_ch_q     <= 3'h0;
      auto_ch_q    <= 3'h0;
      gap_cnt_q    <= 8'h00;
      conv_start_o <= 1'b0;
      conv_chan_o  <= 3'h0;
    end else begin
      conv_start_o <= 1'b0;
      unique case (state_q)
        adcc_pkg::CV_IDLE: begin
          if (!cal_bit_q && !pu_busy_q) begin
            if (read_start || man_start) begin
              src_q        <= read_start ? adcc_pkg::SRC_READ
                                         : adcc_pkg::SRC_MAN;
              cur_ch_q     <= chan_sel_q;
              conv_chan_o  <= chan_sel_q;
              conv_start_o <= 1'b1;
              state_q      <= adcc_pkg::CV_CONV;
            // [RQ18] autonomous channel walk
            end else if (auto_start) begin
              src_q        <= adcc_pkg::SRC_AUTO;
              cur_ch_q     <= auto_ch_q;
              conv_chan_o  <= auto_ch_q;
              conv_start_o <= 1'b1;
              state_q      <= adcc_pkg::CV_CONV;
            end else if (auto_en_q) begin
              auto_ch_q <= auto_ch_q + 3'h1;
            end
          end
        end
        adcc_pkg::CV_CONV: begin
          if (conv_done_i) begin
            gap_cnt_q <= 8'h00;
            state_q   <= avg_last ? adcc_pkg::CV_FIN : adcc_pkg::CV_GAP;
          end
        end
        adcc_pkg::CV_GAP: begin
          gap_cnt_q <= gap_cnt_q + 8'h01;
          if (gap_cnt_q == GAP_LAST) begin
            conv_start_o <= 1'b1;
            state_q      <= adcc_pkg::CV_CONV;
          end
        end
        adcc_pkg::CV_FIN: begin
          if (src_q == adcc_pkg::SRC_AUTO) begin
            auto_ch_q <= auto_ch_q + 3'h1;
          end
          state_q <= adcc_pkg::CV_IDLE;
        end
      endcase
    end
  end

  // [RQ9] [RQ11] [RQ17] latest result store
  always_ff @(posedge mclk_i) begin
    if (init) begin
      for (int i = 0; i < 8; i++) begin
        latest_q[i] <= 16'h0000;
      end
    end else if (avg_done) begin
      latest_q[cur_ch_q] <= avg_res;
    end
  end

  // [RQ16] completion flag, set beats clear
  always_ff @(posedge mclk_i) begin
    if (init) begin
      avg_done_q <= 1'b0;
    end else if (avg_done && src_q == adcc_pkg::SRC_MAN && statistics_enable_bit_q) begin
      avg_done_q <= 1'b1;
    end else if (reg_wr_i && reg_addr_i == `ADCC_OFS_STATUS &&
                 reg_wdata_i[`ADCC_ST_AVG_DONE]) begin
      avg_done_q <= 1'b0;
    end
  end

  // [RQ19] window compare on top bits
  assign top12 = avg_res[15:4];
  always_ff @(posedge mclk_i) begin
    if (init) begin
      win_flag_q <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (avg_done && src_q == adcc_pkg::SRC_AUTO && cur_ch_q == 3'(i) &&
            (top12 > thr_hi_q || top12 < thr_lo_q)) begin
          win_flag_q[i] <= 1'b1;
        end else if (reg_wr_i && reg_addr_i == `ADCC_OFS_WIN_FLAG &&
                     reg_wdata_i[i]) begin
          win_flag_q[i] <= 1'b0;
        end
      end
    end
  end

  // [RQ14] bus clock stretch
  always_ff @(posedge mclk_i) begin
    if (init) begin
      stretch_q <= 1'b0;
      hold_q    <= 1'b0;
    end else begin
      if (avg_done && src_q == adcc_pkg::SRC_READ) begin
        stretch_q <= 1'b0;
      end else if (read_start && state_q == adcc_pkg::CV_IDLE &&
                   !cal_bit_q && !pu_busy_q) begin
        stretch_q <= 1'b1;
      end
      hold_q <= stretch_q && !(avg_done && src_q == adcc_pkg::SRC_READ) &&
                (hold_q || !scl_s2_q);
    end
  end
  assign scl_o      = 1'b0;
  assign scl_oe_n_o = !hold_q;

  // read multiplexer
  always_comb begin
    rd_mux = 8'h00;
    if (reg_addr_i >= `ADCC_OFS_RES_BASE &&
        reg_addr_i < (`ADCC_OFS_RES_BASE + 8'h10)) begin
      rd_mux = reg_addr_i[0] ? latest_q[reg_addr_i[3:1]][15:8]
                             : latest_q[reg_addr_i[3:1]][7:0];
    end else begin
      unique case (reg_addr_i)
        // [RQ5] calibration bit readback
        `ADCC_OFS_GENERAL:   rd_mux = {3'h0, auto_en_q, 1'b0, statistics_enable_bit_q,
                                       cal_bit_q, rst_bit_q};
        `ADCC_OFS_STATUS:    rd_mux = {5'h00, !pu_busy_q,
                                       state_q != adcc_pkg::CV_IDLE,
                                       avg_done_q};
        `ADCC_OFS_AVG_SETUP: rd_mux = {5'h00, osr_q};
        `ADCC_OFS_CHAN_SEL:  rd_mux = {5'h00, chan_sel_q};
        `ADCC_OFS_PIN_SEL:   rd_mux = pin_sel_q;
        `ADCC_OFS_DIR:       rd_mux = dir_q;
        `ADCC_OFS_DRIVE:     rd_mux = drive_q;
        `ADCC_OFS_OUT_LVL:   rd_mux = out_lvl_q;
        `ADCC_OFS_IN_LVL:    rd_mux = in_lvl;
        `ADCC_OFS_AUTO_MASK: rd_mux = auto_mask_q;
        `ADCC_OFS_THR_HI_H:  rd_mux = thr_hi_q[11:4];
        `ADCC_OFS_THR_HI_L:  rd_mux = {4'h0, thr_hi_q[3:0]};
        `ADCC_OFS_THR_LO_H:  rd_mux = thr_lo_q[11:4];
        `ADCC_OFS_THR_LO_L:  rd_mux = {4'h0, thr_lo_q[3:0]};
        `ADCC_OFS_WIN_FLAG:  rd_mux = win_flag_q;
        `ADCC_OFS_BUS_ADDR:  rd_mux = {1'b0, bus_addr_q};
        default:             rd_mux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
    end
  end
endmodule : adcc_top

// ---- verif/adcc_top_chk.sv ----
// assertions and covers for the converter control block
`timescale 1ns/1ps
module adcc_top_chk #(
  parameter int unsigned PU_CYCLES  = 50,
  parameter int unsigned RST_CYCLES = 50
) (
  input  wire logic       mclk_i,
  input  wire logic       resetn_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic [2:0] addr_strap_i,
  input  wire logic [6:0] bus_addr_o,
  input  wire logic       ready_o,
  input  wire logic       scl_i,
  input  wire logic       scl_oe_n_o,
  input  wire logic       conv_start_o,
  input  wire logic       conv_done_i,
  input  wire logic       cal_run_o,
  input  wire logic [7:0] analog_en_o,
  input  wire logic [7:0] gpio_oe_n_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  logic        rdy_q1;
  logic        rdy_q2;
  int unsigned low_cnt_q;
  int unsigned sr_cnt_q;

  always_ff @(posedge mclk_i) begin
    rdy_q1 <= ready_o;
    rdy_q2 <= rdy_q1;
  end
  always_ff @(posedge mclk_i) begin
    if (!resetn_i || ready_o) low_cnt_q <= 0;
    else low_cnt_q <= low_cnt_q + 1;
  end
  always_ff @(posedge mclk_i) begin
    if (!resetn_i || !ready_o) sr_cnt_q <= 0;
    else if (sr_cnt_q != 0 || (reg_wr_i && reg_addr_i == 8'h00
                               && reg_wdata_i[0])) sr_cnt_q <= sr_cnt_q + 1;
  end

  a_reset_analog: assert property ($rose(resetn_i) |->
    analog_en_o == 8'hff && gpio_oe_n_o == 8'hff) else $error("not analog");
  a_ready_early: assert property ($rose(resetn_i) |-> !ready_o [*8])
    else $error("ready too soon");
  a_ready_bound: assert property (
    low_cnt_q <= PU_CYCLES + RST_CYCLES + 4) else $error("ready too late");
  a_soft_done: assert property (sr_cnt_q <= RST_CYCLES + 3)
    else $error("soft reset too long");
  a_cal_bounded: assert property ($rose(cal_run_o) |->
    ##[1:300] !cal_run_o) else $error("calibration never ends");
  a_addr_held: assert property ($changed(bus_addr_o) |->
    $past(reg_wr_i && reg_addr_i == 8'h0f) || ready_o != rdy_q1
    || rdy_q1 != rdy_q2) else $error("address changed");
  a_addr_strap: assert property ($rose(ready_o) |->
    ##[0:1] bus_addr_o == {4'h2, addr_strap_i}) else $error("bad address");
  a_start_gap: assert property ($rose(conv_start_o) |=>
    !conv_start_o [*8]) else $error("starts too close");
  a_start_ready: assert property (
    conv_start_o |-> ready_o && !cal_run_o)
    else $error("start while not ready");
  a_stretch_end: assert property ($rose(scl_oe_n_o) |->
    $past(conv_done_i) || $past(conv_done_i, 2) || $past(conv_done_i, 3))
    else $error("stretch released early");
  a_stretch_low: assert property ($fell(scl_oe_n_o) |->
    !$past(scl_i) || !$past(scl_i, 2) || !$past(scl_i, 3) || !$past(scl_i, 4))
    else $error("stretch with clock high");
  a_analog_undriven: assert property (
    (analog_en_o & ~gpio_oe_n_o) == 8'h00) else $error("analog pin driven");

  c_stretch: cover property ($fell(scl_oe_n_o));
  c_cal: cover property ($fell(cal_run_o));
  c_conv: cover property (conv_start_o ##1 !conv_start_o);
endmodule : adcc_top_chk

bind adcc_top adcc_top_chk #(
  .PU_CYCLES(PU_CYCLES),
  .RST_CYCLES(RST_CYCLES)
) i_adcc_top_chk (
  .mclk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .addr_strap_i,
  .bus_addr_o, .ready_o, .scl_i, .scl_oe_n_o, .conv_start_o, .conv_done_i,
  .cal_run_o, .analog_en_o, .gpio_oe_n_o
);

// ---- verif/adcc_conv_model.sv ----
// converter core model: one result per start, prompt or slow
`timescale 1ns/1ps
module adcc_conv_model (
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  input  wire logic        start_i,
  input  wire logic        slow_i,
  input  wire logic [11:0] val_i,
  output logic             done_o,
  output logic [11:0]      data_o
);
  int unsigned cnt_q;

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) cnt_q <= 0;
    else if (start_i) cnt_q <= slow_i ? 40 : 3;
    else if (cnt_q != 0) cnt_q <= cnt_q - 1;
  end
  // data is only valid with done, it scrambles otherwise
  always_ff @(posedge mclk_i) begin
    done_o <= resetn_i && cnt_q == 1;
    if (!resetn_i) data_o <= 12'h000;
    else if (cnt_q == 1) data_o <= val_i;
    else data_o <= ~data_o;
  end
endmodule : adcc_conv_model

// ---- verif/adcc_top_tb_top.sv ----
// self-checking bench for the converter control block
`timescale 1ns/1ps
module adcc_top_tb_top;
  localparam int PU = 50;
  logic        mclk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [2:0]  addr_strap_i = 3'h0;
  logic        scl_gen = 1'b1;
  logic        scl_run = 1'b0;
  logic        slow = 1'b0;
  logic [11:0] conv_val = 12'h000;
  logic [7:0]  pin_ext = 8'h00;
  logic [7:0]  reg_rdata_o, gpio_o, gpio_oe_n_o, analog_en_o, chan_seen;
  logic [6:0]  bus_addr_o;
  logic [2:0]  conv_chan_o;
  logic [11:0] conv_data_i;
  logic        ready_o, scl_o, scl_oe_n_o, conv_start_o, conv_done_i;
  logic        cal_run_o;
  int          starts = 0;
  int          error_cnt = 0;
  int          checks = 0;
  wire         scl_i = scl_gen & (scl_oe_n_o | scl_o);
  wire  [7:0]  gpio_i = (gpio_oe_n_o & pin_ext) | (~gpio_oe_n_o & gpio_o);

  always #4 mclk_i = ~mclk_i;
  always #80 scl_gen = scl_run ? ~scl_gen : 1'b1;
  always @(posedge mclk_i) if (conv_start_o) begin
    starts <= starts + 1;
    chan_seen[conv_chan_o] <= 1'b1;
  end

  adcc_top #(.PU_CYCLES(PU), .RST_CYCLES(50)) i_adcc_top (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .addr_strap_i(addr_strap_i),
    .bus_addr_o(bus_addr_o), .ready_o(ready_o), .scl_i(scl_i),
    .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o), .conv_start_o(conv_start_o),
    .conv_chan_o(conv_chan_o), .conv_done_i(conv_done_i),
    .conv_data_i(conv_data_i), .cal_run_o(cal_run_o),
    .analog_en_o(analog_en_o), .gpio_i(gpio_i), .gpio_o(gpio_o),
    .gpio_oe_n_o(gpio_oe_n_o));
  adcc_conv_model i_adcc_conv_model (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .start_i(conv_start_o),
    .slow_i(slow), .val_i(conv_val), .done_o(conv_done_i),
    .data_o(conv_data_i));

  task automatic summarize();
    if (error_cnt == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : rd
  task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
    logic [7:0] d;
    for (int i = 0; i < 20000; i++) begin
      rd(a, d);
      if (d[b] === v) break;
    end
    chk(d[b], v);
  endtask : wait_bit
  task automatic wait_ready(input int lo, input int hi);
    int n;
    for (n = 0; n < 300 && ready_o !== 1'b1; n++) begin
      @(posedge mclk_i);
      #1;
    end
    chk(n >= lo && n <= hi, 1'b1);
    repeat (2) @(posedge mclk_i);
    #1;
  endtask : wait_ready
  task automatic avg_run(input logic [2:0] averaging_count_field, input logic [11:0] v);
    logic [7:0]  lo, hi;
    logic [15:0] m;
    int          s0;
    conv_val <= v;
    slow <= averaging_count_field[0];
    m = {v, 4'h0};
    wr(8'h02, {5'h00, averaging_count_field});
    wr(8'h01, 8'h01);
    s0 = starts;
    wr(8'h00, 8'h0c);
    wait_bit(8'h01, 0, 1'b1);
    rd(8'h14, lo);
    rd(8'h15, hi);
    chk({hi, lo}, m + (m >> 12));
    chk(16'(starts - s0), 16'(1 << averaging_count_field));
  endtask : avg_run

  initial begin
    logic [7:0]  d;
    logic [11:0] vals [4];
    int          s0;
    vals = '{12'h000, 12'h800, 12'hfff, 12'h5a3};
    for (int i = 0; i < 8; i++) begin
      addr_strap_i <= i[2:0];
      resetn_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
      resetn_i <= 1'b1;
      wait_ready(PU, PU + 3);
      chk(bus_addr_o, {9'h002, i[2:0]});
    end
    wr(8'h04, 8'hf0);
    wr(8'h05, 8'hc0);
    wr(8'h06, 8'h80);
    wr(8'h07, 8'h00);
    pin_ext <= 8'ha5;
    repeat (4) @(posedge mclk_i);
    #1 chk(analog_en_o, 8'h0f);
    chk(gpio_oe_n_o, 8'h3f);
    rd(8'h08, d);
    chk(d & 8'h30, 8'h20);
    wr(8'h07, 8'hff);
    #1 chk(gpio_oe_n_o, 8'h7f);
    chk(gpio_o[7:6], 2'b11);
    addr_strap_i <= 3'h2;
    repeat (8) @(posedge mclk_i);
    #1 chk(bus_addr_o, 7'h17);
    wr(8'h0f, 8'h2a);
    #1 chk(bus_addr_o, 7'h2a);
    wr(8'h00, 8'h01);
    rd(8'h00, d);
    chk(d[0], 1'b1);
    wait_bit(8'h00, 0, 1'b0);
    wait_ready(0, 299);
    chk(bus_addr_o, 7'h12);
    chk({analog_en_o, gpio_oe_n_o}, 16'hffff);
    wr(8'h00, 8'h02);
    #1 chk(cal_run_o, 1'b1);
    wait_bit(8'h00, 1, 1'b0);
    wr(8'h03, 8'h02);
    for (int k = 0; k < 8; k++) avg_run(k[2:0], vals[k % 4]);
    wr(8'h00, 8'h00);
    wr(8'h02, 8'h02);
    conv_val <= 12'h123;
    scl_run <= 1'b1;
    s0 = starts;
    rd(8'h15, d);
    for (int n = 0; n < 200 && scl_oe_n_o !== 1'b0; n++) @(posedge mclk_i);
    chk(scl_oe_n_o, 1'b0);
    chk(scl_o, 1'b0);
    for (int n = 0; n < 2000 && scl_oe_n_o !== 1'b1; n++) @(posedge mclk_i);
    chk(16'(starts - s0), 16'h0004);
    scl_run <= 1'b0;
    wr(8'h00, 8'h04);
    rd(8'h14, d);
    chk(d, 8'h31);
    rd(8'h15, d);
    chk(d, 8'h12);
    wr(8'h09, 8'h05);
    wr(8'h02, 8'h01);
    wr(8'h0a, 8'h7f);
    wr(8'h0b, 8'h0f);
    wr(8'h0e, 8'hff);
    conv_val <= 12'h800;
    chan_seen <= 8'h00;
    wr(8'h00, 8'h10);
    wait_bit(8'h0e, 2, 1'b1);
    wr(8'h00, 8'h00);
    rd(8'h0e, d);
    chk(d, 8'h05);
    chk(chan_seen, 8'h05);
    summarize();
  end

  initial begin
    #800000;
    error_cnt++;
    summarize();
  end
endmodule : adcc_top_tb_top
